// [pkg/harmonic_config_regs.vh]
/*
  register offsets, field positions, reset values and timing figures of the
  harmonic configuration block.
  assumes: included by the design files by bare name; 25 MHz clock.
*/
`ifndef HARMONIC_CONFIG_REGS_VH
`define HARMONIC_CONFIG_REGS_VH

// register byte addresses (16-bit address port)
`define HCFG_ADDR_CONFIG      16'hE900
`define HCFG_ADDR_STATUS      16'hE904
`define HCFG_ADDR_MASK        16'hE908
`define HCFG_ADDR_STATE       16'hE90C

// field positions of the configuration register
`define HCFG_READY_MODE_BIT   0
`define HCFG_CHAN_LSB         1
`define HCFG_SETTLE_LSB       3
`define HCFG_RATE_LSB         5
`define HCFG_TBASE_LSB        8
`define HCFG_USED_MSB         9

// reset value: settling 01, everything else 0
`define HCFG_CONFIG_RESET     16'h0008
`define HCFG_MASK_RESET       2'h0
`define HCFG_STATUS_RESET     2'h0

// status bit positions
`define HCFG_STAT_READY_BIT   0
`define HCFG_STAT_UPDATE_BIT  1

// disabled rate code
`define HCFG_RATE_OFF         3'h7

// clock rate and base tick period
`define HCFG_CLK_HZ           25000000
`define HCFG_TICK_US          125
`define HCFG_TICK_CYCLES      ((`HCFG_CLK_HZ / 1000000) * `HCFG_TICK_US)

// settling delays in ms, converted to base ticks (8 ticks per ms)
`define HCFG_SETTLE0_MS       500
`define HCFG_SETTLE1_MS       750
`define HCFG_SETTLE2_MS       1000
`define HCFG_SETTLE3_MS       1250
`define HCFG_TICKS_PER_MS     8

// update periods in base ticks: 125us, 250us, 1ms, 16ms, 128ms, 512ms, 1.024s
`define HCFG_RATE0_TICKS      14'h0001
`define HCFG_RATE1_TICKS      14'h0002
`define HCFG_RATE2_TICKS      14'h0008
`define HCFG_RATE3_TICKS      14'h0080
`define HCFG_RATE4_TICKS      14'h0400
`define HCFG_RATE5_TICKS      14'h1000
`define HCFG_RATE6_TICKS      14'h2000

`endif

// [hw/tick_divider.v]
/*
  free-running divider giving a one-cycle enable every period cycles.
  assumes: single clock, asynchronous active-low reset, clear restarts it.
*/
`timescale 1ns/1ps
module tick_divider #(
  parameter W      = 12,
  parameter PERIOD = 3125
) (
  input  wire         clk_i,
  input  wire         rst_n_i,
  input  wire         clear_i,
  output reg          tick_o
);
  localparam integer LAST_I = PERIOD - 1;
  localparam [W-1:0] LAST   = LAST_I[W-1:0];
  reg [W-1:0] cnt_q;

  // count up the period, pulse on wrap
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q  <= {W{1'b0}};
      tick_o <= 1'b0;
    end
    else if (clear_i)
    begin
      cnt_q  <= {W{1'b0}};
      tick_o <= 1'b0;
    end
    else if (cnt_q == LAST)
    begin
      cnt_q  <= {W{1'b0}};
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      tick_o <= 1'b0;
    end
  end
endmodule

// [hw/harmonic_calc_config.v]
/*
  harmonic calculation configuration register with ready/update event timing,
  sticky status, mask and one interrupt line.
  assumes: 25 MHz clk_i, register port with one-cycle strobes and read data
  one cycle after the read strobe; setup_i marks harmonic block set up.
  the base tick restarts on every configuration write, so the first period
  after setup may be short; later periods are exact.
*/
`timescale 1ns/1ps
`include "harmonic_config_regs.vh"
module harmonic_calc_config #(
  parameter SETTLE_SCALE = `HCFG_TICKS_PER_MS
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire [15:0] addr_i,
  input  wire [15:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  input  wire        setup_i,
  output reg  [15:0] rdata_o,
  output reg  [1:0]  channel_sel_o,
  output reg  [1:0]  time_base_sel_o,
  output reg         calc_enable_o,
  output reg         update_o,
  output reg         ready_o,
  output reg         irq_o
);
  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_SETTLE = 2'h1;
  localparam [1:0] ST_RUN    = 2'h2;
  localparam integer TICK_CYC = `HCFG_TICK_CYCLES;
  // settling delays in base ticks, cut to the 14-bit wait counter
  localparam integer SETTLE0_I = `HCFG_SETTLE0_MS * SETTLE_SCALE;
  localparam integer SETTLE1_I = `HCFG_SETTLE1_MS * SETTLE_SCALE;
  localparam integer SETTLE2_I = `HCFG_SETTLE2_MS * SETTLE_SCALE;
  localparam integer SETTLE3_I = `HCFG_SETTLE3_MS * SETTLE_SCALE;
  localparam [13:0]  SETTLE0_T = SETTLE0_I[13:0];
  localparam [13:0]  SETTLE1_T = SETTLE1_I[13:0];
  localparam [13:0]  SETTLE2_T = SETTLE2_I[13:0];
  localparam [13:0]  SETTLE3_T = SETTLE3_I[13:0];

  reg  [15:0] harmonic_config_q;
  reg  [1:0]  status_q;
  reg  [1:0]  mask_q;
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [13:0] wait_q;
  reg  [13:0] wait_d;
  reg  [13:0] settle_ticks;
  reg  [13:0] rate_ticks;
  reg         fire;
  reg         setup_s1_q;
  reg         setup_s2_q;
  reg         setup_s3_q;
  wire        tick;
  wire        ready_mode_select;
  wire [1:0]  analysed_channel_select;
  wire [1:0]  settling_time_select;
  wire [2:0]  update_rate_select;
  wire [1:0]  time_base_phase_select;
  wire        disabled;
  wire        cfg_wr;
  wire        setup_rise;
  wire        mask_wr;
  wire        stat_wr;
  wire [1:0]  stat_clr;

  // configuration fields
  assign ready_mode_select       = harmonic_config_q[`HCFG_READY_MODE_BIT];
  assign analysed_channel_select = harmonic_config_q[`HCFG_CHAN_LSB+1:`HCFG_CHAN_LSB];
  assign settling_time_select    = harmonic_config_q[`HCFG_SETTLE_LSB+1:`HCFG_SETTLE_LSB];
  assign update_rate_select      = harmonic_config_q[`HCFG_RATE_LSB+2:`HCFG_RATE_LSB];
  assign time_base_phase_select  = harmonic_config_q[`HCFG_TBASE_LSB+1:`HCFG_TBASE_LSB];
  assign disabled                = (update_rate_select == `HCFG_RATE_OFF);
  assign cfg_wr                  = wr_i && (addr_i == `HCFG_ADDR_CONFIG);
  assign setup_rise              = setup_s2_q && !setup_s3_q;
  // mask and status write decode, status clear bits
  assign mask_wr                 = wr_i && (addr_i == `HCFG_ADDR_MASK);
  assign stat_wr                 = wr_i && (addr_i == `HCFG_ADDR_STATUS);
  assign stat_clr                = stat_wr ? wdata_i[1:0] : 2'h0;

  // 125 us base tick, restarted on every configuration write
  // its phase is not tied to setup, so the first run period may be short
  tick_divider #(
    .W      (12),
    .PERIOD (TICK_CYC)
  ) u_tick (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .clear_i (cfg_wr),
    .tick_o  (tick)
  );

  // settling delay in base ticks
  // only the ready-mode-0 path loads it
  always @*
  begin
    case (settling_time_select)
      2'h0:    settle_ticks = SETTLE0_T;
      2'h1:    settle_ticks = SETTLE1_T;
      2'h2:    settle_ticks = SETTLE2_T;
      default: settle_ticks = SETTLE3_T;
    endcase
  end

  // update period in base ticks
  always @*
  begin
    case (update_rate_select)
      3'h0:    rate_ticks = `HCFG_RATE0_TICKS;
      3'h1:    rate_ticks = `HCFG_RATE1_TICKS;
      3'h2:    rate_ticks = `HCFG_RATE2_TICKS;
      3'h3:    rate_ticks = `HCFG_RATE3_TICKS;
      3'h4:    rate_ticks = `HCFG_RATE4_TICKS;
      3'h5:    rate_ticks = `HCFG_RATE5_TICKS;
      default: rate_ticks = `HCFG_RATE6_TICKS;
    endcase
  end

  // setup is an external level: two stages, then edge detect
  // only the second stage reads the first, so metastability stays contained
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      setup_s1_q <= 1'b0;
      setup_s2_q <= 1'b0;
      setup_s3_q <= 1'b0;
    end
    else
    begin
      setup_s1_q <= setup_i;
      setup_s2_q <= setup_s1_q;
      setup_s3_q <= setup_s2_q;
    end
  end

  // event sequencer: idle, settle, run
  always @*
  begin
    state_d = state_q;
    wait_d  = wait_q;
    fire    = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (setup_rise && !disabled)
        begin
          if (ready_mode_select)
          begin
            fire    = 1'b1;
            wait_d  = rate_ticks;
            state_d = ST_RUN;
          end
          else
          begin
            wait_d  = settle_ticks;
            state_d = ST_SETTLE;
          end
        end
      end
      ST_SETTLE:
      begin
        if (tick)
        begin
          if (wait_q <= 14'h0001)
          begin
            fire    = 1'b1;
            wait_d  = rate_ticks;
            state_d = ST_RUN;
          end
          else
          begin
            wait_d = wait_q - 14'h0001;
          end
        end
      end
      ST_RUN:
      begin
        if (tick)
        begin
          if (wait_q <= 14'h0001)
          begin
            fire   = 1'b1;
            wait_d = rate_ticks;
          end
          else
          begin
            wait_d = wait_q - 14'h0001;
          end
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
    // a config write or disable sends the block back to await setup
    // setup dropping idles too, so the next rise restarts the sequence
    if (disabled || cfg_wr || !setup_s2_q)
    begin
      state_d = ST_IDLE;
      wait_d  = 14'h0000;
      fire    = 1'b0;
    end
  end

  // sequencer registers
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= ST_IDLE;
      wait_q  <= 14'h0000;
    end
    else
    begin
      state_q <= state_d;
      wait_q  <= wait_d;
    end
  end

  // configuration register; reserved bits are always stored as zero
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      harmonic_config_q <= `HCFG_CONFIG_RESET;
    end
    else if (cfg_wr)
    begin
      harmonic_config_q <= {6'h00, wdata_i[`HCFG_USED_MSB:0]};
    end
  end

  // interrupt mask, same layout as status
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mask_q <= `HCFG_MASK_RESET;
    end
    else if (mask_wr)
    begin
      mask_q <= wdata_i[1:0];
    end
  end

  // sticky status, write-one-to-clear; a new event wins over the clear
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      status_q <= `HCFG_STATUS_RESET;
    end
    else
    begin
      status_q <= (status_q & ~stat_clr) | {fire, fire};
    end
  end

  // read data, one cycle after the strobe; unmapped reads give zero
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o <= 16'h0000;
    end
    else if (rd_i)
    begin
      if (addr_i == `HCFG_ADDR_CONFIG)
        rdata_o <= harmonic_config_q;
      else if (addr_i == `HCFG_ADDR_STATUS)
        rdata_o <= {14'h0000, status_q};
      else if (addr_i == `HCFG_ADDR_MASK)
        rdata_o <= {14'h0000, mask_q};
      else if (addr_i == `HCFG_ADDR_STATE)
        rdata_o <= {13'h0000, ~disabled, state_q};
      else
        rdata_o <= 16'h0000;
    end
    else
    begin
      rdata_o <= 16'h0000;
    end
  end

  // registered block outputs
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      channel_sel_o   <= 2'h0;
      time_base_sel_o <= 2'h0;
      calc_enable_o   <= 1'b0;
    end
    else
    begin
      channel_sel_o   <= analysed_channel_select;
      // reserved 11 maps onto phase C
      time_base_sel_o <= (time_base_phase_select == 2'h3) ? 2'h2 : time_base_phase_select;
      calc_enable_o   <= !disabled;
    end
  end

  // event pulses, one cycle per ready or update event
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      update_o <= 1'b0;
      ready_o  <= 1'b0;
    end
    else
    begin
      update_o <= fire;
      ready_o  <= fire;
    end
  end

  // level interrupt, high while an unmasked status bit is set
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(status_q & mask_q);
    end
  end
endmodule

// [dv/harmonic_calc_config_assertions.sv]
/* port checker for harmonic_calc_config.
   assumes: one clock, async active-low reset. */
`timescale 1ns/1ps
module harmonic_calc_config_assertions #(
  parameter SETTLE_SCALE = 8
) (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic        setup_i,
  input wire logic [15:0] rdata_o,
  input wire logic [1:0]  channel_sel_o,
  input wire logic [1:0]  time_base_sel_o,
  input wire logic        calc_enable_o,
  input wire logic        update_o,
  input wire logic        ready_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire        cfg_wr = wr_i && addr_i == 16'hE900;
  reg  [15:0] last_q;
  // last value written to config
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) last_q <= 16'h0008;
    else if (cfg_wr) last_q <= wdata_i;
  a_pulse_pair: assert property (ready_o == update_o) else $error("pulses differ");
  a_ready_prompt: assert property ($rose(setup_i) && last_q[0] && last_q[7:5] != 3'h7 |-> ##[2:4] ready_o)
    else $error("no prompt ready");
  a_off_quiet: assert property (!calc_enable_o |-> !update_o && !ready_o) else $error("update while off");
  a_enable_code: assert property (cfg_wr |-> ##2 calc_enable_o == (last_q[7:5] != 3'h7))
    else $error("enable wrong");
  a_chan_follow: assert property (cfg_wr |-> ##2 channel_sel_o == last_q[2:1])
    else $error("channel wrong");
  a_tbase_map: assert property (cfg_wr |-> ##2 time_base_sel_o == (last_q[9:8] == 2'h3 ? 2'h2 : last_q[9:8]))
    else $error("time base wrong");
  a_rsvd_zero: assert property ($past(rd_i) |-> rdata_o[15:10] == 6'h00) else $error("reserved set");
  a_write_idles: assert property (cfg_wr |-> ##2 !update_o [*3]) else $error("pulse after write");
  a_irq_cause: assert property ($rose(irq_o) |-> $past(ready_o) || $past(wr_i, 2))
    else $error("irq without cause");
endmodule
bind harmonic_calc_config harmonic_calc_config_assertions #(.SETTLE_SCALE(SETTLE_SCALE)) u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .setup_i(setup_i), .rdata_o(rdata_o), .channel_sel_o(channel_sel_o), .time_base_sel_o(time_base_sel_o),
  .calc_enable_o(calc_enable_o), .update_o(update_o), .ready_o(ready_o), .irq_o(irq_o));

// [dv/tb_harmonic_calc_config.sv]
/* self-checking bench for harmonic_calc_config.
   assumes: 25 MHz clock, settling scale cut to 1. */
`timescale 1ns/1ps
module tb_harmonic_calc_config;
  logic        clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, setup_i = 0;
  logic [15:0] addr_i = 0, wdata_i = 0;
  wire  [15:0] rdata_o;
  wire  [1:0]  channel_sel_o, time_base_sel_o;
  wire         calc_enable_o, update_o, ready_o, irq_o;
  int          err_total = 0, comparisons = 0, cyc = 0, n;
  always #20 clk_i = ~clk_i;
  harmonic_calc_config #(.SETTLE_SCALE(1)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .setup_i(setup_i), .rdata_o(rdata_o),
    .channel_sel_o(channel_sel_o), .time_base_sel_o(time_base_sel_o), .calc_enable_o(calc_enable_o),
    .update_o(update_o), .ready_o(ready_o), .irq_o(irq_o));
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_total++;
      conclude;
    end
  end
  task chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i <= 1; addr_i <= a; wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 0;
  endtask
  task rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk_i);
    rd_i <= 1; addr_i <= a;
    @(posedge clk_i);
    rd_i <= 0;
    @(negedge clk_i);
    chk(rdata_o, e);
  endtask
  // new rising edge on setup
  task arm;
    @(posedge clk_i);
    setup_i <= 0;
    repeat (4) @(posedge clk_i);
    setup_i <= 1;
  endtask
  // cycles until next ready pulse, bounded
  task gap(input int lim);
    n = 0;
    do begin @(negedge clk_i); n++; end while (ready_o !== 1'b1 && n < lim);
  endtask
  task t_reset;
    rd(16'hE900, 16'h0008);
    rd(16'hE908, 16'h0000);
    rd(16'hE904, 16'h0000);
    rd(16'hE90C, 16'h0004);
    rd(16'hE902, 16'h0000);
    chk({15'h0, calc_enable_o}, 16'h0001);
    chk({15'h0, irq_o}, 16'h0000);
    $display("reset test done");
  endtask
  task t_fields;
    logic [15:0] d;
    for (int i = 0; i < 16; i++)
    begin
      d = {6'h3F, i[3:2], 5'h01, i[1:0], 1'b0};
      wr(16'hE900, d);
      repeat (2) @(negedge clk_i);
      chk({14'h0, channel_sel_o}, {14'h0, i[1:0]});
      chk({14'h0, time_base_sel_o}, (i[3:2] == 2'h3) ? 16'h2 : {14'h0, i[3:2]});
      rd(16'hE900, d & 16'h03FF);
    end
    wr(16'hE900, 16'h00E8);
    repeat (2) @(negedge clk_i);
    chk({15'h0, calc_enable_o}, 16'h0000);
    $display("field test done");
  endtask
  task t_mode1;
    wr(16'hE908, 16'h0003);
    wr(16'hE900, 16'h0001);
    arm;
    gap(6);
    chk({15'h0, ready_o}, 16'h0001);
    chk({15'h0, update_o}, 16'h0001);
    @(negedge clk_i);
    chk({15'h0, irq_o}, 16'h0001);
    rd(16'hE904, 16'h0003);
    rd(16'hE90C, 16'h0006);
    gap(4000);
    gap(4000);
    chk(n[15:0], 16'h0C35);
    wr(16'hE904, 16'h0003);
    rd(16'hE904, 16'h0000);
    chk({15'h0, irq_o}, 16'h0000);
    wr(16'hE908, 16'h0000);
    wr(16'hE900, 16'h0039);
    arm;
    gap(6);
    chk({15'h0, ready_o}, 16'h0001);
    gap(7000);
    gap(7000);
    chk(n[15:0], 16'h186A);
    chk({15'h0, irq_o}, 16'h0000);
    $display("ready mode 1 test done");
  endtask
  task t_quiet(input logic [15:0] cfg, input int lim, input logic [15:0] st);
    wr(16'hE900, cfg);
    arm;
    gap(lim);
    chk({15'h0, ready_o}, 16'h0000);
    rd(16'hE90C, st);
    $display("quiet test done");
  endtask
  // reset in mid-settle, then the reset values again
  task t_rerst;
    @(posedge clk_i);
    rst_n_i <= 0;
    setup_i <= 0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1;
    t_reset;
  endtask
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1;
    t_reset;
    t_fields;
    t_mode1;
    t_quiet(16'h00E1, 8000, 16'h0000);
    t_quiet(16'h0000, 10000, 16'h0005);
    t_rerst;
    conclude;
  end
endmodule
